// file: logic/adcc_pkg.sv
package adcc_pkg;
   // Register byte addresses on the Wishbone bus.
   localparam logic [4:0] ADCC_OFS_REF_CHAN = 5'h00;
   localparam logic [4:0] ADCC_OFS_CSR_PRI = 5'h04;
   localparam logic [4:0] ADCC_OFS_CSR_SEC = 5'h08;
   localparam logic [4:0] ADCC_OFS_RES_LOW = 5'h0C;
   localparam logic [4:0] ADCC_OFS_RES_HIGH = 5'h10;
   localparam int ADCC_ADDR_W = 5;
   localparam logic [7:0] ADCC_RESET_BYTE = 8'h00;

   // Reference and channel select register fields.
   localparam int ADCC_REF_HI = 7;
   localparam int ADCC_REF_LO = 6;
   localparam int ADCC_LEFT_BIT = 5;
   localparam int ADCC_CHAN_HI = 4;
   localparam int ADCC_CHAN_LO = 0;

   // Primary control and status register fields.
   localparam int ADCC_EN_BIT = 7;
   localparam int ADCC_START_BIT = 6;
   localparam int ADCC_AUTO_BIT = 5;
   localparam int ADCC_FLAG_BIT = 4;
   localparam int ADCC_IE_BIT = 3;
   localparam int ADCC_DIV_HI = 2;
   localparam int ADCC_DIV_LO = 0;

   // Secondary control register fields.
   localparam int ADCC_HSM_BIT = 7;
   localparam int ADCC_CURRENT_SOURCE_INPUT_BIT = 6;
   localparam int ADCC_ANALOG_REFERENCE_PIN_BIT = 5;
   localparam int ADCC_TRIG_HI = 3;
   localparam int ADCC_TRIG_LO = 0;
   localparam logic [7:0] ADCC_SEC_WMASK = 8'hEF;

   // Reference codes.
   localparam logic [1:0] ADCC_REF_EXT = 2'h0;
   localparam logic [1:0] ADCC_REF_AVCC = 2'h1;
   localparam logic [1:0] ADCC_REF_RSVD = 2'h2;
   localparam logic [1:0] ADCC_REF_INT = 2'h3;

   // Channel codes.
   localparam logic [4:0] ADCC_CH_TEMP = 5'h0B;
   localparam logic [4:0] ADCC_CH_BANDGAP = 5'h11;
   localparam logic [4:0] ADCC_CH_LAST = 5'h12;
   localparam int ADCC_CH_COUNT = 19;

   // Trigger sources: zero is free running, the reserved codes start here.
   localparam logic [3:0] ADCC_TRIG_FREE = 4'h0;
   localparam logic [3:0] ADCC_TRIG_RSVD = 4'hE;
   localparam int ADCC_TRIG_COUNT = 14;

   // Prescaler codes at or below this divide by two.
   localparam logic [2:0] ADCC_DIV_MIN_CODE = 3'h1;
   localparam int ADCC_DIV_CNT_W = 7;

   localparam int ADCC_RES_W = 10;
endpackage

// file: logic/adcc_clk_if.sv
`timescale 1ns/1ps
interface adcc_clk_if;
   logic [2:0] div_sel;
   logic tick;
   modport src (input div_sel, output tick);
   modport sink (output div_sel, input tick);
endinterface

// file: logic/adcc_prescaler.sv
`timescale 1ns/1ps
module adcc_prescaler
   import adcc_pkg::*;
#(
   parameter int CNT_W = ADCC_DIV_CNT_W
)
(
   // Clock and control.
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Divider select in, converter clock tick out.
   adcc_clk_if.src clk_if
);
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic [CNT_W-1:0] last_count;
   logic [CNT_W:0] divisor;
   logic tick_reg;
   wire at_last;

   // The two lowest codes both divide by two.
   assign divisor = (clk_if.div_sel <= ADCC_DIV_MIN_CODE) ? (CNT_W+1)'(2) : (CNT_W+1)'(1) << clk_if.div_sel;
   assign last_count = CNT_W'(divisor - (CNT_W+1)'(1));
   assign at_last = (cnt_reg >= last_count);
   assign cnt_next = at_last ? '0 : cnt_reg + CNT_W'(1);
   assign clk_if.tick = tick_reg;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt_reg <= '0;
         tick_reg <= 1'b0;
      end
      else if (ce_i)
      begin
         cnt_reg <= cnt_next;
         tick_reg <= at_last;
      end
   end
endmodule

// file: logic/adcc_top.sv
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module adcc_top
   import adcc_pkg::*;
#(
   parameter int RES_W = ADCC_RES_W
)
(
   // Clock, reset and clock enable.
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone classic slave.
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [adcc_pkg::ADCC_ADDR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Conversion core.
   output logic core_power_o,
   output logic conv_go_o,
   output logic conv_init_o,
   output logic conv_busy_o,
   output logic adc_clk_tick_o,
   output logic high_speed_o,
   input wire logic conv_done_i,
   input wire logic [RES_W-1:0] conv_data_i,
   // Input multiplexer.
   output logic [adcc_pkg::ADCC_CH_COUNT-1:0] chan_route_o,
   output logic chan_valid_o,
   // Reference switches.
   output logic ref_ext_o,
   output logic ref_avcc_o,
   output logic ref_int_o,
   output logic ref_valid_o,
   output logic int_ref_on_o,
   output logic ref_pin_connect_o,
   output logic current_source_o,
   // Trigger flags and interrupt.
   input wire logic [adcc_pkg::ADCC_TRIG_COUNT-1:0] trig_flags_i,
   input wire logic irq_ack_i,
   output logic irq_o
);
   import adcc_pkg::*;

   typedef enum logic [2:0] {
      ADCC_IDLE = 3'b001,
      ADCC_LAUNCH = 3'b010,
      ADCC_CONVERT = 3'b100
   } adcc_state_t;

   adcc_state_t state_reg, state_next;
   logic [7:0] ref_chan_reg;
   logic [7:0] csr_pri_reg;
   logic [7:0] csr_sec_reg;
   logic [1:0] active_ref_reg;
   logic [4:0] active_chan_reg;
   logic power_reg;
   logic first_reg;
   logic [RES_W-1:0] result_reg;
   logic lock_reg;
   logic [ADCC_TRIG_COUNT-1:0] trig_prev_reg;
   logic ack_reg;
   logic [7:0] dat_reg;

   adcc_clk_if clk_bus ();

   adcc_prescaler #(
      .CNT_W(ADCC_DIV_CNT_W)
   ) u_prescaler (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .clk_if(clk_bus)
   );

   // Bus decode. A request is taken in the cycle before ack rises.
   wire bus_req = cyc_i && stb_i && !ack_reg;
   wire bus_wr = bus_req && we_i && sel_i[0];
   wire bus_rd = bus_req && !we_i;
   wire hit_ref = (adr_i == ADCC_OFS_REF_CHAN);
   wire hit_pri = (adr_i == ADCC_OFS_CSR_PRI);
   wire hit_sec = (adr_i == ADCC_OFS_CSR_SEC);
   wire hit_low = (adr_i == ADCC_OFS_RES_LOW);
   wire hit_high = (adr_i == ADCC_OFS_RES_HIGH);
   wire [7:0] wbyte = dat_i[7:0];
   wire wr_pri = bus_wr && hit_pri;

   // Field views.
   wire en_bit = csr_pri_reg[ADCC_EN_BIT];
   wire start_bit = csr_pri_reg[ADCC_START_BIT];
   wire auto_bit = csr_pri_reg[ADCC_AUTO_BIT];
   wire flag_bit = csr_pri_reg[ADCC_FLAG_BIT];
   wire ie_bit = csr_pri_reg[ADCC_IE_BIT];
   wire left_bit = ref_chan_reg[ADCC_LEFT_BIT];
   wire [3:0] trig_sel = csr_sec_reg[ADCC_TRIG_HI:ADCC_TRIG_LO];
   wire busy = (state_reg != ADCC_IDLE);
   wire done = (state_reg == ADCC_CONVERT) && conv_done_i;

   // Rising edge of the selected flag; flag n sits at trigger code n.
   wire [ADCC_TRIG_COUNT-1:0] trig_rise = trig_flags_i & ~trig_prev_reg;
   wire trig_ok = (trig_sel != ADCC_TRIG_FREE) && (trig_sel < ADCC_TRIG_RSVD);
   // A disabled converter ignores trigger edges, so no start can be armed behind its back.
   wire trig_hit = en_bit && auto_bit && trig_ok && trig_rise[trig_sel];
   wire free_run = auto_bit && (trig_sel == ADCC_TRIG_FREE);

   // Only a written one starts; a written zero leaves the start bit alone.
   wire sw_start = wr_pri && wbyte[ADCC_START_BIT] && wbyte[ADCC_EN_BIT];
   wire start_req = (start_bit || trig_hit) && power_reg && !busy;

   // Flag: the set wins over both clears.
   wire flag_clr = irq_ack_i || (wr_pri && wbyte[ADCC_FLAG_BIT]);
   wire flag_next = done || (flag_bit && !flag_clr);

   // Start bit stays up while converting, drops at completion unless free running restarts.
   wire start_next = sw_start || trig_hit || (start_bit && !done) || (done && free_run);

   wire [7:0] pri_next = {
      (wr_pri ? wbyte[ADCC_EN_BIT] : en_bit),
      (en_bit || wbyte[ADCC_EN_BIT]) ? start_next : 1'b0,
      (wr_pri ? wbyte[ADCC_AUTO_BIT] : auto_bit),
      flag_next,
      (wr_pri ? wbyte[ADCC_IE_BIT] : ie_bit),
      (wr_pri ? wbyte[ADCC_DIV_HI:ADCC_DIV_LO] : csr_pri_reg[ADCC_DIV_HI:ADCC_DIV_LO])
   };

   // State machine.
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ADCC_IDLE:
            if (start_req)
               state_next = ADCC_LAUNCH;
         ADCC_LAUNCH:
            state_next = ADCC_CONVERT;
         ADCC_CONVERT:
            if (conv_done_i)
               state_next = ADCC_IDLE;
         default:
            state_next = ADCC_IDLE;
      endcase
   end

   // Result justification is combinational so a justify write shows at once.
   wire [15:0] res_left = {result_reg, 6'h00};
   wire [15:0] res_right = {6'h00, result_reg};
   wire [15:0] res_view = left_bit ? res_left : res_right;

   wire [7:0] rd_byte = hit_ref ? ref_chan_reg :
                        hit_pri ? csr_pri_reg :
                        hit_sec ? csr_sec_reg :
                        hit_low ? res_view[7:0] :
                        hit_high ? res_view[15:8] : ADCC_RESET_BYTE;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_reg <= 1'b0;
         dat_reg <= ADCC_RESET_BYTE;
      end
      else if (ce_i)
      begin
         ack_reg <= bus_req;
         if (bus_rd)
            dat_reg <= rd_byte;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ref_chan_reg <= ADCC_RESET_BYTE;
         csr_pri_reg <= ADCC_RESET_BYTE;
         csr_sec_reg <= ADCC_RESET_BYTE;
      end
      else if (ce_i)
      begin
         if (bus_wr && hit_ref)
            ref_chan_reg <= wbyte;
         if (bus_wr && hit_sec)
            csr_sec_reg <= wbyte & ADCC_SEC_WMASK;
         csr_pri_reg <= pri_next;
      end
   end

   // Reference, channel and power used by the analog side move only between conversions.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         active_ref_reg <= ADCC_REF_EXT;
         active_chan_reg <= 5'h00;
         power_reg <= 1'b0;
      end
      else if (ce_i && !busy)
      begin
         active_ref_reg <= ref_chan_reg[ADCC_REF_HI:ADCC_REF_LO];
         active_chan_reg <= ref_chan_reg[ADCC_CHAN_HI:ADCC_CHAN_LO];
         power_reg <= en_bit;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg <= ADCC_IDLE;
         first_reg <= 1'b0;
         trig_prev_reg <= '0;
      end
      else if (ce_i)
      begin
         state_reg <= state_next;
         trig_prev_reg <= trig_flags_i;
         if (!power_reg && en_bit && !busy)
            first_reg <= 1'b1;
         else if (done)
            first_reg <= 1'b0;
      end
   end

   // A completion that arrives while frozen still raises the flag but its data is dropped.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         result_reg <= '0;
         lock_reg <= 1'b0;
      end
      else if (ce_i)
      begin
         if (done && !lock_reg)
            result_reg <= conv_data_i;
         if (bus_rd && hit_high)
            lock_reg <= 1'b0;
         else if (bus_rd && hit_low)
            lock_reg <= 1'b1;
      end
   end

   // Analog-side decode.
   wire ref_valid = (active_ref_reg != ADCC_REF_RSVD);
   wire chan_valid = (active_chan_reg <= ADCC_CH_LAST);
   wire needs_int = (active_ref_reg == ADCC_REF_INT) || (active_chan_reg == ADCC_CH_TEMP)
                    || (active_chan_reg == ADCC_CH_BANDGAP);

   genvar gi;
   generate
      for (gi = 0; gi < ADCC_CH_COUNT; gi++)
      begin : g_route
         assign chan_route_o[gi] = power_reg && (active_chan_reg == 5'(gi));
      end
   endgenerate

   assign clk_bus.div_sel = csr_pri_reg[ADCC_DIV_HI:ADCC_DIV_LO];
   assign adc_clk_tick_o = clk_bus.tick;
   assign dat_o = {24'h000000, dat_reg};
   assign ack_o = ack_reg;
   assign core_power_o = power_reg;
   assign conv_go_o = (state_reg == ADCC_LAUNCH);
   assign conv_init_o = first_reg && busy;
   assign conv_busy_o = busy;
   assign high_speed_o = csr_sec_reg[ADCC_HSM_BIT];
   assign chan_valid_o = chan_valid;
   assign ref_ext_o = (active_ref_reg == ADCC_REF_EXT);
   assign ref_avcc_o = (active_ref_reg == ADCC_REF_AVCC);
   assign ref_int_o = (active_ref_reg == ADCC_REF_INT);
   assign ref_valid_o = ref_valid;
   assign int_ref_on_o = power_reg && needs_int;
   assign ref_pin_connect_o = csr_sec_reg[ADCC_ANALOG_REFERENCE_PIN_BIT] && !csr_sec_reg[ADCC_CURRENT_SOURCE_INPUT_BIT];
   assign current_source_o = csr_sec_reg[ADCC_CURRENT_SOURCE_INPUT_BIT];
   assign irq_o = flag_bit && ie_bit;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_running;
      ce_i && busy ##1 busy;
   endsequence

   sequence s_launch;
      ce_i && start_req ##1 conv_go_o;
   endsequence

   a_ref_held_busy: assert property (s_running |-> active_ref_reg == $past(active_ref_reg))
      else $error("reference changed during conversion");
   a_chan_held_busy: assert property (s_running |-> active_chan_reg == $past(active_chan_reg))
      else $error("channel changed during conversion");
   a_power_held: assert property (ce_i && busy && power_reg |=> power_reg || !$past(busy))
      else $error("converter powered down mid conversion");
   a_launch_start: assert property (s_launch ##0 ce_i |=> state_reg == ADCC_CONVERT)
      else $error("launch did not enter conversion");
   a_flag_on_done: assert property (ce_i && done |=> flag_bit)
      else $error("done flag not set after completion");
   a_zero_write_kept: assert property (ce_i && wr_pri && !wbyte[ADCC_START_BIT] && start_bit && !done && en_bit
                                       && wbyte[ADCC_EN_BIT] |=> start_bit)
      else $error("written zero cleared start bit");
   a_flag_clear: assert property (ce_i && flag_bit && irq_ack_i && !done |=> !flag_bit)
      else $error("acknowledge did not clear done flag");
   a_irq_gate: assert property (ce_i && done && ie_bit && !wr_pri |=> irq_o)
      else $error("interrupt request not raised after completion");
   a_lock_freeze: assert property (ce_i && lock_reg && !(bus_rd && hit_high) |=> $stable(result_reg))
      else $error("result changed while frozen");
   a_left_view: assert property (left_bit |-> res_view[15:6] == result_reg && res_view[5:0] == 6'h00)
      else $error("left justified view wrong");
   a_trig_edge: assert property (ce_i && trig_hit && !wr_pri |=> start_bit)
      else $error("trigger edge did not start");
   a_init_first: assert property (ce_i && !power_reg && en_bit && !busy |=> first_reg)
      else $error("initialisation not armed on enable");
   a_start_clear: assert property (ce_i && done && !free_run && !sw_start && !trig_hit |=> !start_bit)
      else $error("start bit not cleared at completion");
   a_route_onehot: assert property ($onehot0(chan_route_o))
      else $error("more than one input routed");
endmodule

// file: tb/adcc_core_model.sv
`timescale 1ns/1ps
module adcc_core_model #(
   parameter int DLY = 8
)
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Start in, completion and result out.
   input wire logic go_i,
   input wire logic [9:0] result_i,
   output logic done_o,
   output logic [9:0] data_o
);
   int cnt;
   // Outside the done pulse the data lines churn, so a late sample cannot pass by luck.
   always @(posedge clk_i)
   begin
      done_o <= 1'b0;
      data_o <= ~data_o;
      if (rst_i)
      begin
         cnt <= 0;
         data_o <= 10'h155;
      end
      else if (go_i)
         cnt <= DLY;
      else if (cnt == 1)
      begin
         cnt <= 0;
         done_o <= 1'b1;
         data_o <= result_i;
      end
      else if (cnt > 1)
         cnt <= cnt - 1;
   end
endmodule

// file: tb/adcc_top_tb_top.sv
`timescale 1ns/1ps
module adcc_top_tb_top;
   import adcc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [4:0] adr_i = 5'h00;
   logic [3:0] sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic ack_o, core_power_o, conv_go_o, conv_init_o, conv_busy_o, adc_clk_tick_o, high_speed_o;
   logic done, chan_valid_o, ref_ext_o, ref_avcc_o, ref_int_o, ref_valid_o, int_ref_on_o;
   logic ref_pin_connect_o, current_source_o, irq_o;
   logic [9:0] cdata;
   logic [9:0] result = 10'h0;
   logic [18:0] chan_route_o;
   logic [13:0] trig_flags_i = 14'h0;
   logic irq_ack_i = 1'b0;
   int n_fail = 0;
   int n_tests = 0;
   localparam logic [3:0] REXP [4] = '{4'h9, 4'h5, 4'h0, 4'h3};

   always #50 clk_i = ~clk_i;

   adcc_top u_adcc_top (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
      .ack_o, .core_power_o, .conv_go_o, .conv_init_o, .conv_busy_o, .adc_clk_tick_o, .high_speed_o,
      .conv_done_i(done), .conv_data_i(cdata), .chan_route_o, .chan_valid_o, .ref_ext_o, .ref_avcc_o,
      .ref_int_o, .ref_valid_o, .int_ref_on_o, .ref_pin_connect_o, .current_source_o, .trig_flags_i,
      .irq_ack_i, .irq_o);
   adcc_core_model u_adcc_core_model (.clk_i, .rst_i, .go_i(conv_go_o), .result_i(result), .done_o(done),
      .data_o(cdata));

   task conclude;
      $display("n_fail=%0d n_tests=%0d", n_fail, n_tests);
      if (n_fail == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e)
      begin
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
         n_fail++;
      end
   endtask

   task hang;
      $display("BAD t=%0t got=%h exp=%h", $time, 0, 1);
      n_fail++;
      conclude();
   endtask

   // The request stays up until the edge that samples ack; data is taken at that edge.
   task wb(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h000000, d};
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack_o !== 1'b1 && n < 20);
      if (n >= 20)
         hang();
      q = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask

   task wr(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, a, d, q);
      @(negedge clk_i);
   endtask

   task rdc(input logic [4:0] a, input logic [7:0] e);
      logic [7:0] q;
      wb(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask

   // Waits at falling edges for go (sel 0) or busy (sel 1) to reach v.
   task wait_on(input int sel, input logic v);
      int n;
      n = 0;
      while ((sel ? conv_busy_o : conv_go_o) !== v && n < 300)
      begin
         @(negedge clk_i);
         n++;
      end
      if (n >= 300)
         hang();
   endtask

   task conv(input logic [9:0] d);
      result <= d;
      wr(ADCC_OFS_CSR_PRI, 8'hC8);
      wait_on(0, 1'b1);
      wait_on(1, 1'b0);
      @(negedge clk_i);
   endtask

   task t_reset;
      rdc(ADCC_OFS_REF_CHAN, 8'h00);
      rdc(ADCC_OFS_CSR_PRI, 8'h00);
      rdc(ADCC_OFS_CSR_SEC, 8'h00);
      rdc(ADCC_OFS_RES_LOW, 8'h00);
      rdc(ADCC_OFS_RES_HIGH, 8'h00);
      rdc(5'h14, 8'h00);
   endtask

   task t_conv;
      wr(ADCC_OFS_REF_CHAN, 8'h05);
      result <= 10'h2A5;
      wr(ADCC_OFS_CSR_PRI, 8'hC8);
      wait_on(0, 1'b1);
      chk(conv_init_o, 1);
      wr(ADCC_OFS_REF_CHAN, 8'hCB);
      chk(chan_route_o, 32'h20);
      chk(ref_ext_o, 1);
      wait_on(1, 1'b0);
      @(negedge clk_i);
      @(negedge clk_i);
      chk(irq_o, 1);
      rdc(ADCC_OFS_CSR_PRI, 8'h98);
      chk(chan_route_o, 32'h800);
      chk(ref_int_o, 1);
      chk(int_ref_on_o, 1);
      rdc(ADCC_OFS_RES_LOW, 8'hA5);
      rdc(ADCC_OFS_RES_HIGH, 8'h02);
      wr(ADCC_OFS_REF_CHAN, 8'hEB);
      rdc(ADCC_OFS_RES_LOW, 8'h40);
      rdc(ADCC_OFS_RES_HIGH, 8'hA9);
   endtask

   task t_flag;
      wr(ADCC_OFS_CSR_PRI, 8'h88);
      rdc(ADCC_OFS_CSR_PRI, 8'h98);
      wr(ADCC_OFS_CSR_PRI, 8'h80);
      chk(irq_o, 0);
      wr(ADCC_OFS_CSR_PRI, 8'h90);
      rdc(ADCC_OFS_CSR_PRI, 8'h80);
      conv(10'h3C1);
      chk(irq_o, 1);
      @(posedge clk_i);
      irq_ack_i <= 1'b1;
      @(posedge clk_i);
      irq_ack_i <= 1'b0;
      @(negedge clk_i);
      chk(irq_o, 0);
   endtask

   task t_freeze;
      wr(ADCC_OFS_REF_CHAN, 8'h05);
      conv(10'h123);
      rdc(ADCC_OFS_RES_LOW, 8'h23);
      result <= 10'h2FE;
      wr(ADCC_OFS_CSR_PRI, 8'hC8);
      wait_on(0, 1'b1);
      chk(conv_init_o, 0);
      wr(ADCC_OFS_CSR_PRI, 8'h88);
      chk(conv_busy_o, 1);
      wait_on(1, 1'b0);
      rdc(ADCC_OFS_RES_HIGH, 8'h01);
      conv(10'h2FE);
      rdc(ADCC_OFS_RES_LOW, 8'hFE);
      rdc(ADCC_OFS_RES_HIGH, 8'h02);
   endtask

   task t_sel;
      for (int c = 0; c < 21; c++)
      begin
         wr(ADCC_OFS_REF_CHAN, 8'(c));
         chk(chan_route_o, (c < 19) ? (32'h1 << c) : 32'h0);
         chk(chan_valid_o, c < 19);
      end
      for (int r = 0; r < 4; r++)
      begin
         wr(ADCC_OFS_REF_CHAN, 8'(r << 6));
         chk({ref_ext_o, ref_avcc_o, ref_int_o, ref_valid_o}, REXP[r]);
         chk(int_ref_on_o, r == 3);
      end
      wr(ADCC_OFS_CSR_SEC, 8'hF0);
      rdc(ADCC_OFS_CSR_SEC, 8'hE0);
      chk({high_speed_o, current_source_o, ref_pin_connect_o}, 3'h6);
      wr(ADCC_OFS_CSR_SEC, 8'h20);
      chk({high_speed_o, current_source_o, ref_pin_connect_o}, 3'h1);
   endtask

   task t_div;
      int n;
      for (int k = 0; k < 8; k++)
      begin
         wr(ADCC_OFS_CSR_PRI, 8'h80 | 8'(k));
         wait_tick(n);
         wait_tick(n);
         chk(n, (k < 2) ? 2 : (1 << k));
      end
      // With the clock enable low the divider must not tick at all, even across a full period.
      @(posedge clk_i);
      ce_i <= 1'b0;
      n = 0;
      repeat (200)
      begin
         @(negedge clk_i);
         n += int'(adc_clk_tick_o);
      end
      chk(n, 0);
      @(posedge clk_i);
      ce_i <= 1'b1;
   endtask

   task wait_tick(output int n);
      n = 0;
      do
      begin
         @(negedge clk_i);
         n++;
      end
      while (adc_clk_tick_o !== 1'b1 && n < 300);
      if (n >= 300)
         hang();
   endtask

   task t_auto;
      wr(ADCC_OFS_CSR_SEC, 8'h03);
      wr(ADCC_OFS_CSR_PRI, 8'hA8);
      chk(conv_busy_o, 0);
      @(posedge clk_i);
      trig_flags_i <= 14'h0008;
      wait_on(0, 1'b1);
      wr(ADCC_OFS_CSR_PRI, 8'h00);
      chk({core_power_o, conv_busy_o}, 2'h3);
      wait_on(1, 1'b0);
      @(negedge clk_i);
      @(negedge clk_i);
      chk(core_power_o, 0);
      @(posedge clk_i);
      trig_flags_i <= 14'h0000;
      wr(ADCC_OFS_CSR_PRI, 8'h88);
      @(posedge clk_i);
      trig_flags_i <= 14'h0008;
      repeat (6) @(negedge clk_i);
      chk(conv_busy_o, 0);
      // Free running: only the first conversion is started by software.
      wr(ADCC_OFS_CSR_SEC, 8'h00);
      wr(ADCC_OFS_CSR_PRI, 8'hE8);
      wait_on(1, 1'b0);
      wait_on(1, 1'b1);
      chk(conv_busy_o, 1);
      wr(ADCC_OFS_CSR_PRI, 8'h88);
      wait_on(1, 1'b0);
      repeat (4) @(negedge clk_i);
      chk(conv_busy_o, 0);
      rdc(ADCC_OFS_CSR_PRI, 8'h98);
   endtask

   initial
   begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_conv();
      t_flag();
      t_freeze();
      t_sel();
      t_div();
      t_auto();
      conclude();
   end
endmodule
